// ==== pkg/tic_pkg.sv ====
// Shared constants and types for the triple interval counter block.
// Assumes a single 25 MHz system clock and an 8-bit byte-wide register port.
`default_nettype none

package tic_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] TIC_ADR_CTR0 = 4'h8;
    localparam logic [3:0] TIC_ADR_CTR1 = 4'h9;
    localparam logic [3:0] TIC_ADR_CTR2 = 4'hA;
    localparam logic [3:0] TIC_ADR_CTRL = 4'hB;
    localparam logic [3:0] TIC_ADR_AUX = 4'hC;

    // Control byte field positions
    localparam int TIC_POS_COUNTER_PICK_HIGH = 7;
    localparam int TIC_POS_COUNTER_PICK_LOW = 6;
    localparam int TIC_POS_ACCESS_ORDER_HIGH = 5;
    localparam int TIC_POS_ACCESS_ORDER_LOW = 4;
    localparam int TIC_POS_OP_SELECT_TOP = 3;
    localparam int TIC_POS_OP_SELECT_BOTTOM = 1;
    localparam int TIC_POS_BCD = 0;
    // Readback command fields
    localparam int TIC_POS_COUNT_LATCH_N = 5;
    localparam int TIC_POS_FLAGS_LATCH_N = 4;
    localparam int TIC_POS_READBACK_PICK_FIRST = 1;
    localparam logic [1:0] TIC_PICK_READBACK = 2'h3;

    // Access orders
    localparam logic [1:0] TIC_RW_LATCH = 2'h0;
    localparam logic [1:0] TIC_RW_LO = 2'h1;
    localparam logic [1:0] TIC_RW_HI = 2'h2;
    localparam logic [1:0] TIC_RW_BOTH = 2'h3;

    // Effective operating modes
    localparam logic [2:0] TIC_MODE_0 = 3'h0;
    localparam logic [2:0] TIC_MODE_1 = 3'h1;
    localparam logic [2:0] TIC_MODE_2 = 3'h2;
    localparam logic [2:0] TIC_MODE_3 = 3'h3;
    localparam logic [2:0] TIC_MODE_4 = 3'h4;
    localparam logic [2:0] TIC_MODE_5 = 3'h5;

    // Auxiliary register bits and reset value
    localparam int TIC_AUX_EXT_CLK = 0;
    localparam int TIC_AUX_DIV_GATE = 1;
    localparam logic [1:0] TIC_AUX_RST = 2'h0;

    // Timing: internal count source derived from the system clock
    localparam int TIC_CLK_HZ = 25_000_000;
    localparam int TIC_SRC_HZ = 1_000_000;
    localparam int TIC_PRE_DIV = TIC_CLK_HZ / TIC_SRC_HZ;
    localparam logic [4:0] TIC_PRE_LAST = 5'(TIC_PRE_DIV - 1);

    // One counter's complete state
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] rw;
        logic bcd;
        logic [15:0] cr;
        logic [15:0] ce;
        logic [15:0] ol;
        logic ol_valid;
        logic ol_hi;
        logic [7:0] stat;
        logic st_valid;
        logic wr_tog;
        logic rd_tog;
        logic null_cnt;
        logic load_pend;
        logic armed;
        logic trig;
        logic out;
    } tic_ctr_t;

endpackage

`default_nettype wire

// ==== hw/tic_top.sv ====
// Three 16-bit down counters behind a byte-wide register port.
// Assumes one 25 MHz clock; counter 0 pins come from outside and are synchronised here.
//
// Operation
// - three 16-bit presettable down counters, each programmed separately
// - counters one and two chained, gated divider
// - counter zero pin-gated, internal or external clock
// - mode 0 low on load, high at zero
// - mode 1 trigger starts retriggerable low pulse
// - mode 2 one-clock low pulse every N
// - mode 3 square wave, odd split unevenly
// - mode 3 steps down by two each clock, odd counts first by one (high) or three (low)
// - mode 4 strobe after load, gate inhibits
// - mode 5 strobe after full count from trigger
// - top two bits pick counter or readback
// - bits five, four pick access order
// - bits three to one pick mode
// - bit zero picks binary or decimal counting
// - latch command holds count, counting continues
// - low-then-high bytes alternate through toggle
// - readback latches flagged counts together
// - readback latches status byte per counter
// - null count set until count transfers
// - status, low, high read in order
// - further latches ignored until hold read
// - status read first ahead of held count
`default_nettype none

module tic_top
    import tic_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Counter zero pins
    input wire logic ctr0_clk_pin,
    input wire logic ctr0_gate_pin,
    output logic ctr0_out,
    // Divider output
    output logic div_out
);

    // Whole block state in one record
    typedef struct packed {
        tic_ctr_t [2:0] ctr;
        logic [4:0] pre;
        logic [2:0] ck_s;
        logic ck_f;
        logic [2:0] gt_s;
        logic gt_f;
        logic [1:0] aux;
        logic g12_prev;
        logic out1_prev;
        logic [7:0] rdata;
    } tic_state_t;

    tic_state_t s;        // Registered state
    tic_state_t s_nxt;    // Next state
    logic [1:0] rst_sync; // Reset release pipeline
    logic rst_n;          // Synchronised reset
    logic [2:0] tick;     // Count pulse per counter
    logic [2:0] gate;     // Gate level per counter
    logic [2:0] rise;     // Gate rising edge per counter
    logic tick_src;       // Internal 1 MHz pulse
    logic ck_rise;        // Filtered external clock edge
    logic ctl_wr;         // Write to the control port

    // One step down, binary or four-digit decimal
    function automatic logic [15:0] tic_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic brw;
        r = v;
        brw = 1'b1;
        if (!bcd)
            r = v - 16'h0001;
        else
            for (int d = 0; d < 4; d++)
            begin
                if (brw)
                begin
                    if (r[d*4 +: 4] == 4'h0)
                        r[d*4 +: 4] = 4'h9;
                    else
                    begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        return r;
    endfunction

    // Top mode bit is a don't-care for modes 2 and 3
    function automatic logic [2:0] tic_eff_mode(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction

    // Reset release: asynchronous assert, two-flop release
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Count sources; filtered pin edges only count once two samples agree
    assign tick_src = (s.pre == TIC_PRE_LAST);
    assign ck_rise = (s.ck_s[1] == s.ck_s[2]) && s.ck_s[2] && !s.ck_f;
    assign tick[0] = s.aux[TIC_AUX_EXT_CLK] ? ck_rise : tick_src;
    assign tick[1] = tick_src;
    assign tick[2] = s.ctr[1].out && !s.out1_prev;
    assign gate[0] = s.gt_f;
    assign gate[1] = s.aux[TIC_AUX_DIV_GATE];
    assign gate[2] = s.aux[TIC_AUX_DIV_GATE];
    assign rise[0] = (s.gt_s[1] == s.gt_s[2]) && s.gt_s[2] && !s.gt_f;
    assign rise[1] = s.aux[TIC_AUX_DIV_GATE] && !s.g12_prev;
    assign rise[2] = s.aux[TIC_AUX_DIV_GATE] && !s.g12_prev;
    assign ctl_wr = wr && (addr == TIC_ADR_CTRL);

    // Next-state logic for the whole block
    always_comb
    begin
        tic_ctr_t c;
        logic [2:0] em;
        logic [15:0] n1;
        logic [15:0] n2;
        logic [15:0] n3;
        logic [15:0] src;
        logic hi;
        logic done;
        logic first;
        c = '0;
        em = TIC_MODE_0;
        n1 = '0;
        n2 = '0;
        n3 = '0;
        src = '0;
        hi = 1'b0;
        done = 1'b0;
        first = 1'b0;
        s_nxt = s;
        s_nxt.rdata = 8'h00;
        // Prescaler for the internal count source
        s_nxt.pre = tick_src ? 5'h00 : s.pre + 5'h01;
        // Pin synchronisers and agreement filters
        s_nxt.ck_s = {s.ck_s[1:0], ctr0_clk_pin};
        s_nxt.gt_s = {s.gt_s[1:0], ctr0_gate_pin};
        if (s.ck_s[1] == s.ck_s[2])
            s_nxt.ck_f = s.ck_s[2];
        if (s.gt_s[1] == s.gt_s[2])
            s_nxt.gt_f = s.gt_s[2];
        s_nxt.g12_prev = s.aux[TIC_AUX_DIV_GATE];
        s_nxt.out1_prev = s.ctr[1].out;
        // Auxiliary register: clock pick and divider gate
        if (wr && addr == TIC_ADR_AUX)
            s_nxt.aux = wdata[1:0];
        if (rd && addr == TIC_ADR_AUX)
            s_nxt.rdata = {6'h00, s.aux};
        for (int i = 0; i < 3; i++)
        begin
            c = s.ctr[i];
            em = tic_eff_mode(c.mode);
            n1 = tic_dec(c.ce, c.bcd);
            n2 = tic_dec(n1, c.bcd);
            n3 = tic_dec(n2, c.bcd);
            // Counting on this counter's own clock
            if (tick[i])
            begin
                unique case (em)
                    TIC_MODE_0, TIC_MODE_4:
                    begin
                        if (em == TIC_MODE_4)
                            c.out = 1'b1;
                        if (c.load_pend)
                        begin
                            c.ce = c.cr;
                            c.load_pend = 1'b0;
                            c.null_cnt = 1'b0;
                        end
                        else if (gate[i])
                        begin
                            c.ce = n1;
                            if (c.armed && n1 == 16'h0000)
                            begin
                                c.armed = 1'b0;
                                c.out = (em == TIC_MODE_0);
                            end
                        end
                    end
                    TIC_MODE_1, TIC_MODE_5:
                    begin
                        if (em == TIC_MODE_5)
                            c.out = 1'b1;
                        if (c.trig)
                        begin
                            c.ce = c.cr;
                            c.trig = 1'b0;
                            c.load_pend = 1'b0;
                            c.null_cnt = 1'b0;
                            c.armed = 1'b1;
                            c.out = (em == TIC_MODE_5);
                        end
                        else
                        begin
                            c.ce = n1;
                            if (c.armed && n1 == 16'h0000)
                            begin
                                c.armed = 1'b0;
                                c.out = (em == TIC_MODE_1);
                            end
                        end
                    end
                    TIC_MODE_2:
                    begin
                        first = c.trig || (c.load_pend && !c.armed);
                        if (!gate[i])
                            c.out = 1'b1;
                        // Nothing counts until a count has been loaded
                        else if (first || (c.armed && c.ce == 16'h0001))
                        begin
                            c.ce = c.cr;
                            c.out = 1'b1;
                            c.armed = 1'b1;
                            c.trig = 1'b0;
                            c.load_pend = 1'b0;
                            c.null_cnt = 1'b0;
                        end
                        else if (c.armed)
                        begin
                            c.ce = n1;
                            c.out = (n1 != 16'h0001);
                        end
                    end
                    TIC_MODE_3:
                    begin
                        first = c.trig || (c.load_pend && !c.armed);
                        if (!gate[i])
                            c.out = 1'b1;
                        // Low phase of a count of 3 ends after its single step of three
                        else if (first || (c.armed && (c.ce == 16'h0002
                            || (!c.out && c.ce == 16'h0003))))
                        begin
                            c.out = first ? 1'b1 : !c.out;
                            c.ce = c.cr;
                            c.armed = 1'b1;
                            c.trig = 1'b0;
                            c.load_pend = 1'b0;
                            c.null_cnt = 1'b0;
                        end
                        // Odd start: one extra step high, one short low
                        else if (c.armed && c.ce[0])
                            c.ce = c.out ? n1 : n3;
                        else if (c.armed)
                            c.ce = n2;
                    end
                    default:
                        c.out = 1'b1;
                endcase
            end
            // Modes 2 and 3 hold the output high while gated off
            if ((em == TIC_MODE_2 || em == TIC_MODE_3) && !gate[i])
                c.out = 1'b1;
            // Control byte addressed to this counter
            if (ctl_wr && wdata[TIC_POS_COUNTER_PICK_HIGH:TIC_POS_COUNTER_PICK_LOW] == 2'(i))
            begin
                if (wdata[TIC_POS_ACCESS_ORDER_HIGH:TIC_POS_ACCESS_ORDER_LOW] == TIC_RW_LATCH)
                begin
                    if (!c.ol_valid)
                    begin
                        c.ol = s.ctr[i].ce;
                        c.ol_valid = 1'b1;
                        c.ol_hi = 1'b0;
                    end
                end
                else
                begin
                    c.rw = wdata[TIC_POS_ACCESS_ORDER_HIGH:TIC_POS_ACCESS_ORDER_LOW];
                    c.mode = wdata[TIC_POS_OP_SELECT_TOP:TIC_POS_OP_SELECT_BOTTOM];
                    c.bcd = wdata[TIC_POS_BCD];
                    c.wr_tog = 1'b0;
                    c.rd_tog = 1'b0;
                    c.load_pend = 1'b0;
                    c.armed = 1'b0;
                    c.trig = 1'b0;
                    c.ol_valid = 1'b0;
                    c.st_valid = 1'b0;
                    c.null_cnt = 1'b1;
                    c.out = (wdata[TIC_POS_OP_SELECT_TOP:TIC_POS_OP_SELECT_BOTTOM] != TIC_MODE_0);
                end
            end
            // Readback command flagging this counter
            if (ctl_wr && wdata[TIC_POS_COUNTER_PICK_HIGH:TIC_POS_COUNTER_PICK_LOW] == TIC_PICK_READBACK
                && wdata[TIC_POS_READBACK_PICK_FIRST + i])
            begin
                if (!wdata[TIC_POS_COUNT_LATCH_N] && !c.ol_valid)
                begin
                    c.ol = s.ctr[i].ce;
                    c.ol_valid = 1'b1;
                    c.ol_hi = 1'b0;
                end
                if (!wdata[TIC_POS_FLAGS_LATCH_N] && !c.st_valid)
                begin
                    c.stat = {s.ctr[i].out, s.ctr[i].null_cnt, s.ctr[i].rw, s.ctr[i].mode, s.ctr[i].bcd};
                    c.st_valid = 1'b1;
                end
            end
            // Count write through the counter's data port
            if (wr && addr == TIC_ADR_CTR0 + 4'(i))
            begin
                done = 1'b0;
                unique case (c.rw)
                    TIC_RW_LO:
                    begin
                        c.cr = {8'h00, wdata};
                        done = 1'b1;
                    end
                    TIC_RW_HI:
                    begin
                        c.cr = {wdata, 8'h00};
                        done = 1'b1;
                    end
                    TIC_RW_BOTH:
                    begin
                        if (!c.wr_tog)
                            c.cr[7:0] = wdata;
                        else
                        begin
                            c.cr[15:8] = wdata;
                            done = 1'b1;
                        end
                        c.wr_tog = !c.wr_tog;
                    end
                    // Never programmed since reset: writes are dropped
                    default:
                        done = 1'b0;
                endcase
                if (done)
                begin
                    c.null_cnt = 1'b1;
                    c.load_pend = 1'b1;
                    if (em == TIC_MODE_0)
                        c.out = 1'b0;
                    if (em == TIC_MODE_0 || em == TIC_MODE_4)
                        c.armed = 1'b1;
                end
            end
            // Data port read: status, then held count, then live count
            if (rd && addr == TIC_ADR_CTR0 + 4'(i))
            begin
                if (c.st_valid)
                begin
                    s_nxt.rdata = c.stat;
                    c.st_valid = 1'b0;
                end
                else
                begin
                    src = c.ol_valid ? c.ol : c.ce;
                    hi = (c.rw == TIC_RW_HI) || (c.rw == TIC_RW_BOTH && (c.ol_valid ? c.ol_hi : c.rd_tog));
                    s_nxt.rdata = hi ? src[15:8] : src[7:0];
                    if (c.ol_valid)
                    begin
                        if (c.rw == TIC_RW_BOTH && !c.ol_hi)
                            c.ol_hi = 1'b1;
                        else
                        begin
                            c.ol_valid = 1'b0;
                            c.ol_hi = 1'b0;
                        end
                    end
                    else if (c.rw == TIC_RW_BOTH)
                        c.rd_tog = !c.rd_tog;
                end
            end
            // Gate edges are sticky until used; a new edge beats the clear
            c.trig = c.trig || rise[i];
            s_nxt.ctr[i] = c;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.aux <= TIC_AUX_RST;
        end
        else if (clk_en)
            s <= s_nxt;
    end

    // Outputs straight from state flops
    assign rdata = s.rdata;
    assign ctr0_out = s.ctr[0].out;
    assign div_out = s.ctr[2].out;

    // Checks on the block's own behaviour
    default clocking tic_cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_mode0_load_low: assert property (clk_en && wr && addr == TIC_ADR_CTR0
        && (s.ctr[0].rw == TIC_RW_LO || (s.ctr[0].rw == TIC_RW_BOTH && s.ctr[0].wr_tog))
        && tic_eff_mode(s.ctr[0].mode) == TIC_MODE_0 |=> !ctr0_out)
        else $error("mode 0 load did not drive output low");
    a_mode0_zero_high: assert property (clk_en && tick[0] && gate[0] && s.ctr[0].armed
        && tic_eff_mode(s.ctr[0].mode) == TIC_MODE_0 && !s.ctr[0].load_pend && s.ctr[0].ce == 16'h0001
        && !wr |=> ctr0_out)
        else $error("mode 0 output not high at zero");
    a_ctrl_toggle_reset: assert property (clk_en && ctl_wr && wdata[7:6] == 2'h1 && wdata[5:4] != TIC_RW_LATCH
        |=> !s.ctr[1].wr_tog && !s.ctr[1].rd_tog && s.ctr[1].null_cnt)
        else $error("control byte did not reset toggles");
    a_latch_capture: assert property (clk_en && ctl_wr && wdata == 8'h00 && !s.ctr[0].ol_valid
        |=> s.ctr[0].ol_valid && s.ctr[0].ol == $past(s.ctr[0].ce))
        else $error("latch did not capture count");
    a_latch_ignored: assert property (clk_en && ctl_wr && wdata[7:4] == 4'h0 && s.ctr[0].ol_valid
        |=> $stable(s.ctr[0].ol))
        else $error("second latch overwrote held count");
    a_status_first: assert property (clk_en && rd && addr == TIC_ADR_CTR0 && s.ctr[0].st_valid
        |=> rdata == $past(s.ctr[0].stat) && !s.ctr[0].st_valid)
        else $error("status byte not returned first");
    a_status_format: assert property (clk_en && ctl_wr && wdata[7:6] == 2'h3 && !wdata[4] && wdata[1]
        && !s.ctr[0].st_valid |=> s.ctr[0].stat == {$past(s.ctr[0].out), $past(s.ctr[0].null_cnt),
        $past(s.ctr[0].rw), $past(s.ctr[0].mode), $past(s.ctr[0].bcd)})
        else $error("status byte layout wrong");
    a_readback_all: assert property (clk_en && ctl_wr && wdata == 8'hDE && !s.ctr[0].ol_valid
        && !s.ctr[2].ol_valid |=> s.ctr[0].ol_valid && s.ctr[2].ol_valid && s.ctr[2].ol == $past(s.ctr[2].ce))
        else $error("readback did not latch all counts");
    a_rate_one_low: assert property (clk_en && tick[1] && gate[1] && !s.ctr[1].out
        && tic_eff_mode(s.ctr[1].mode) == TIC_MODE_2 && !ctl_wr |=> s.ctr[1].out)
        else $error("mode 2 low pulse longer than one clock");
    a_null_clear: assert property (clk_en && tick[0] && s.ctr[0].load_pend && !wr
        && tic_eff_mode(s.ctr[0].mode) == TIC_MODE_0 |=> !s.ctr[0].null_cnt && s.ctr[0].ce == $past(s.ctr[0].cr))
        else $error("null count not cleared on transfer");

    c_square_toggle: cover property (tic_eff_mode(s.ctr[2].mode) == TIC_MODE_3 && $fell(s.ctr[2].out));
    c_div_tick: cover property (tick[2] && gate[2]);
    c_status_read: cover property (rd && addr == TIC_ADR_CTR0 && s.ctr[0].st_valid && s.ctr[0].ol_valid);
    c_strobe: cover property (tic_eff_mode(s.ctr[0].mode) == TIC_MODE_5 && $fell(ctr0_out));

endmodule

`default_nettype wire

// ==== sim/test_triple_interval_counter.sv ====
// Bench for the triple interval counter: register port, counter 0 pins, divider output.
// Assumes the design files are compiled first; clk_en is held high throughout.
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module test_triple_interval_counter
    import tic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Bus, pins and bookkeeping
    logic clock = 0, nrst = 0, wr = 0, rd = 0, gate = 0, ext_clk = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic ctr0_out, div_out;
    logic [7:0] q[$];
    logic [15:0] cnt;
    int fails = 0, comparisons = 0, n, lo, hi, n1, n2;

    tic_top dut_u (.clock(clock), .nrst(nrst), .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ctr0_clk_pin(ext_clk), .ctr0_gate_pin(gate), .ctr0_out(ctr0_out),
        .div_out(div_out));

    // 25 MHz clock
    initial
    begin
        forever #20 clock = ~clock;
    end

    // One-cycle write strobe
    task automatic wrb(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // One-cycle read; data sampled in the following cycle only
    task automatic rdb(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // Bounded wait for an output level; cycles counted in c
    task automatic waitfor(input logic sel, input logic v, output int c);
        for (c = 1; c < 3000; c++)
        begin
            @(posedge clock);
            #1;
            if ((sel ? div_out : ctr0_out) === v)
                return;
        end
        fails++;
        results();
    endtask

    // One external clock pulse; each level held four cycles for the pin filter
    task automatic pulse();
        ext_clk <= 1'b1;
        repeat (4) @(posedge clock);
        ext_clk <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'hbe31));
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rdb(4'h3, 8'h00);
        rdb(TIC_ADR_CTRL, 8'h00);
        $display("test bus done");
        // Gate low keeps the mode 1 count pending
        wrb(TIC_ADR_CTRL, 8'h32);
        wrb(TIC_ADR_CTR0, 8'h05);
        wrb(TIC_ADR_CTR0, 8'h00);
        wrb(TIC_ADR_CTRL, 8'hE2);
        rdb(TIC_ADR_CTR0, 8'hF2);
        // Mode 0 count transfers while the gate is low, then waits
        cnt = 16'($urandom_range(9, 5));
        wrb(TIC_ADR_CTRL, 8'h30);
        wrb(TIC_ADR_CTR0, cnt[7:0]);
        wrb(TIC_ADR_CTR0, cnt[15:8]);
        #1;
        `CHK(ctr0_out, 1'b0)
        repeat (60) @(posedge clock);
        wrb(TIC_ADR_CTRL, 8'hDE);
        wrb(TIC_ADR_CTRL, 8'hC2);
        q = '{8'h30, cnt[7:0], cnt[15:8]};
        while (q.size() > 0)
            rdb(TIC_ADR_CTR0, q.pop_front());
        // Held value survives counting and a second latch
        wrb(TIC_ADR_CTRL, 8'h00);
        gate <= 1'b1;
        repeat (60) @(posedge clock);
        wrb(TIC_ADR_CTRL, 8'h00);
        wrb(TIC_ADR_CTRL, 8'hE2);
        q = '{8'h30, cnt[7:0], cnt[15:8]};
        while (q.size() > 0)
            rdb(TIC_ADR_CTR0, q.pop_front());
        waitfor(1'b0, 1'b1, n);
        // Tick phase and pin filter leave about one tick of slack
        `CHK(n + 70 >= (cnt - 1) * 25 && n + 70 <= cnt * 25 + 40, 1'b1)
        $display("test counter zero done");
        // Chained divider: mode 2 into mode 3 with an odd count
        n1 = $urandom_range(5, 2);
        n2 = 2 * $urandom_range(3, 1) + 1;
        wrb(TIC_ADR_CTRL, 8'h54);
        wrb(TIC_ADR_CTRL, 8'h96);
        wrb(TIC_ADR_CTR1, 8'(n1));
        wrb(TIC_ADR_CTR2, 8'(n2));
        wrb(TIC_ADR_AUX, 8'h02);
        rdb(TIC_ADR_AUX, 8'h02);
        waitfor(1'b1, 1'b0, n);
        waitfor(1'b1, 1'b1, lo);
        waitfor(1'b1, 1'b0, hi);
        `CHK(lo, (n2 - 1) / 2 * n1 * 25)
        `CHK(hi, (n2 + 1) / 2 * n1 * 25)
        $display("test divider done");
        // Mode codes 0 to 5 with a random number format
        for (int m = 0; m < 6; m++)
        begin
            d = {2'b01, 2'b11, 3'(m), 1'($urandom)};
            wrb(TIC_ADR_CTRL, d);
            wrb(TIC_ADR_CTRL, 8'hE4);
            rdb(TIC_ADR_CTR1, {m != 0, 1'b1, d[5:0]});
        end
        $display("test modes done");
        // External clock on counter zero: one edge loads, then one edge per count
        wrb(TIC_ADR_AUX, 8'h03);
        wrb(TIC_ADR_CTRL, 8'h30);
        n = $urandom_range(6, 2);
        wrb(TIC_ADR_CTR0, 8'(n));
        wrb(TIC_ADR_CTR0, 8'h00);
        repeat (n) pulse();
        `CHK(ctr0_out, 1'b0)
        pulse();
        `CHK(ctr0_out, 1'b1)
        $display("test external clock done");
        results();
    end
endmodule

`default_nettype wire
